// ===== include/bank_pkg.sv
// Constants and types shared by the bank select and table access logic
package bank_pkg;
  // Data memory map
  localparam logic [7:0] SFR_WIN_LO = 8'h10;
  localparam logic [7:0] SFR_WIN_HI = 8'h17;
  localparam logic [7:0] GPR_BASE = 8'h20;
  localparam logic [3:0] PBANK_RESERVED = 4'hf;
  localparam int PHYS_W = 10;
  localparam logic [2:0] PHYS_SFR_TAG = 3'h7;
  localparam logic [4:0] PHYS_LOW_TAG = 5'h10;
  localparam logic [0:0] PHYS_GPR_TAG = 1'h0;
  // Bank select nibbles
  localparam int PBANK_LSB = 0;
  localparam int GBANK_LSB = 4;
  localparam logic [7:0] BANK_SEL_RST = 8'h00;
  // Register map, byte addresses
  localparam logic [3:0] REG_BANK_SEL = 4'h0;
  localparam logic [3:0] REG_MODE = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  // Status fields
  localparam int ST_DISCARD = 0;
  localparam int ST_TBL_BUSY = 1;
  localparam int ST_LAST_OK = 2;
  localparam int ST_EXT_ACC = 3;
  // Reset values
  localparam logic [1:0] MODE_RST = 2'h1;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam int PM_ADDR_W = 16;
  typedef enum logic [1:0] {
    MODE_MICROPROC, MODE_MICROCTRL, MODE_EXTENDED, MODE_PROTECTED
  } opmode_t;
  typedef enum logic [1:0] {
    TBL_LATCH_WR, TBL_PROG_WR, TBL_LATCH_RD, TBL_PROG_RD
  } tblop_t;
  typedef enum logic {TS_IDLE, TS_PM_WAIT} tblst_t;
endpackage

// ===== include/bank_if.sv
// Address decode carrier between the top and the bank decoder
`timescale 1ns/1ps
interface bank_if;
  import bank_pkg::*;
  logic [7:0] addr;
  logic [7:0] bankSel;
  logic [PHYS_W-1:0] physIdx;
  logic implemented;
  logic inSfrWin;
  modport dec (input addr, bankSel, output physIdx, implemented, inSfrWin);
  modport user (output addr, bankSel, input physIdx, implemented, inSfrWin);
endinterface

// ===== core/bank_ram.sv
// Physical data memory behind the banked address map
`timescale 1ns/1ps
module bank_ram #(
  parameter int W = 8,
  parameter int AW = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read port, data one cycle later
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// ===== core/bank_decode.sv
// Maps a core data address and bank select onto a physical memory index
`timescale 1ns/1ps
module bank_decode import bank_pkg::*; #(
  parameter bit FULL_BANKING = 1'b1,
  parameter int GPR_BANKS = 2,
  parameter logic [15:0] PBANK_IMPL = 16'h000f
) (
  // Decode carrier
  bank_if.dec bk
);
  wire [3:0] pbank = bk.bankSel[PBANK_LSB +: 4];
  wire [3:0] gbank = FULL_BANKING ? bk.bankSel[GBANK_LSB +: 4] : 4'h0; // RULE4
  wire inWin = (bk.addr >= SFR_WIN_LO) && (bk.addr <= SFR_WIN_HI); // RULE1
  wire inGpr = bk.addr >= GPR_BASE;
  // Reserved bank 15 is only readable if listed in the mask
  wire pbankOk = PBANK_IMPL[pbank]; // RULE7
  wire gbankOk = 32'(gbank) < GPR_BANKS;
  assign bk.inSfrWin = inWin;
  assign bk.physIdx = inWin ? {PHYS_SFR_TAG, pbank, bk.addr[2:0]} : // RULE1 RULE2
    inGpr ? {PHYS_GPR_TAG, gbank[0], bk.addr} : // RULE3
    {PHYS_LOW_TAG, bk.addr[4:0]}; // RULE12
  assign bk.implemented = inWin ? pbankOk : (inGpr ? gbankOk : 1'b1);
endmodule

// ===== core/data_bank_select_table_access.sv
// Data bank selection, unimplemented bank handling and table transfer steering
//
// How it works
// RULE1 - Only 10h-17h banked, by peripheral nibble
// RULE2 - Lower bank nibble picks peripheral bank
// RULE3 - Upper nibble picks RAM bank, full variant
// RULE4 - Reduced variant: lower nibble only, no RAM banking
// RULE5 - Unimplemented bank reads return all zeros
// RULE6 - Unimplemented bank writes dropped, flags still updated
// RULE7 - Software avoids reading reserved peripheral bank 15
// RULE8 - Sixteen-bit words move as two byte operations
// RULE9 - Table writes and reads between both memories
// RULE10 - External program memory only in MP/extended modes
// RULE11 - External program space spans 64K words
// RULE12 - Other addresses pass unaffected by peripheral nibble
`timescale 1ns/1ps
module data_bank_select_table_access import bank_pkg::*; #(
  parameter bit FULL_BANKING = 1'b1,
  parameter int GPR_BANKS = 2,
  parameter logic [15:0] PBANK_IMPL = 16'h000f,
  parameter int INT_PM_WORDS = 2048
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Avalon-MM register slave
  input wire logic [3:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWritedata,
  input wire logic [3:0] avByteenable,
  output logic [31:0] avReaddata,
  output logic avWaitrequest,
  // Core data memory port
  input wire logic [7:0] dmAddr,
  input wire logic dmRead,
  input wire logic dmWrite,
  input wire logic [7:0] dmWdata,
  output logic [7:0] dmRdata,
  output logic dmRvalid,
  // Core bank load instructions
  input wire logic bankLoWe,
  input wire logic bankHiWe,
  input wire logic [3:0] bankNibble,
  output logic [7:0] bankSelect,
  // ALU status flags
  input wire logic aluFlagsWe,
  input wire logic [3:0] aluFlagsIn,
  output logic [3:0] aluFlags,
  // Core table operations
  input wire logic tblReq,
  input wire logic [1:0] tblOp,
  input wire logic tblHigh,
  input wire logic [15:0] tblPtr,
  input wire logic [7:0] tblWdata,
  output logic tblReady,
  output logic [7:0] tblRdata,
  output logic tblRvalid,
  // Program memory port
  output logic [PM_ADDR_W-1:0] pmAddr,
  output logic [15:0] pmWdata,
  output logic pmRead,
  output logic pmWrite,
  output logic pmExternal,
  input wire logic [15:0] pmRdata,
  input wire logic pmAck
);
  if (GPR_BANKS < 1 || GPR_BANKS > 2) begin : gBadBanks
    $error("GPR_BANKS must be 1 or 2");
  end
  if (INT_PM_WORDS < 1 || INT_PM_WORDS > (1 << PM_ADDR_W)) begin : gBadPm
    $error("INT_PM_WORDS out of range");
  end

  function automatic logic [15:0] putByte(logic [15:0] w, logic hi, logic [7:0] b);
    putByte = hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction
  function automatic logic [7:0] getByte(logic [15:0] w, logic hi);
    getByte = hi ? w[15:8] : w[7:0];
  endfunction

  // Registers
  logic [7:0] bankSel_ff, nxt_bankSel;
  logic [1:0] mode_ff, nxt_mode;
  logic discard_ff, nxt_discard;
  logic lastOk_ff;
  logic [3:0] aluFlags_ff;
  logic avWaitreq_ff;
  logic [31:0] avRdata_ff;
  logic rdPend_ff, rdOk_ff;
  logic [7:0] dmRdata_ff;
  logic dmRvalid_ff;
  tblst_t tblSt_ff, nxt_tblSt;
  logic [15:0] latch_ff, nxt_latch;
  logic tblReady_ff;
  logic [7:0] tblRdata_ff, nxt_tblRdata;
  logic tblRvalid_ff, nxt_tblRvalid;
  logic [PM_ADDR_W-1:0] pmAddr_ff, nxt_pmAddr;
  logic [15:0] pmWdata_ff, nxt_pmWdata;
  logic pmRead_ff, nxt_pmRead;
  logic pmWrite_ff, nxt_pmWrite;
  logic pmExt_ff, nxt_pmExt;

  // Address decode
  bank_if bk ();
  assign bk.addr = dmAddr;
  assign bk.bankSel = bankSel_ff;
  bank_decode #(
    .FULL_BANKING(FULL_BANKING),
    .GPR_BANKS(GPR_BANKS),
    .PBANK_IMPL(PBANK_IMPL)
  ) uDecode (
    .bk(bk)
  );

  wire memWe = dmWrite && bk.implemented; // RULE6
  wire dropWr = dmWrite && !bk.implemented; // RULE6
  wire [7:0] memRdata;
  bank_ram #(
    .W(8),
    .AW(PHYS_W)
  ) uRam (
    .clock(clock),
    .sys_rst(sys_rst),
    .we(memWe),
    .waddr(bk.physIdx),
    .wdata(dmWdata),
    .raddr(bk.physIdx),
    .rdata(memRdata)
  );

  // Bus slave decode
  wire avReq = avRead || avWrite;
  wire avAcc = avReq && !avWaitreq_ff;
  wire avWrAcc = avWrite && !avWaitreq_ff && avByteenable[0];
  wire selBank = avAddress == REG_BANK_SEL;
  wire selMode = avAddress == REG_MODE;
  wire selStat = avAddress == REG_STATUS;
  wire [7:0] statusByte = {4'h0, pmExt_ff, lastOk_ff, (tblSt_ff != TS_IDLE), discard_ff};
  wire [31:0] avRdNext = selBank ? {24'h0, bankSel_ff} :
    selMode ? {30'h0, mode_ff} :
    selStat ? {24'h0, statusByte} : 32'h0;
  wire [3:0] hiMask = FULL_BANKING ? 4'hf : 4'h0; // RULE4
  wire [3:0] avLo = (avWrAcc && selBank) ? avWritedata[3:0] : bankSel_ff[3:0];
  wire [3:0] avHi = (avWrAcc && selBank) ? avWritedata[7:4] : bankSel_ff[7:4];
  wire [3:0] loNext = bankLoWe ? bankNibble : avLo; // RULE2
  wire [3:0] hiNext = (bankHiWe ? bankNibble : avHi) & hiMask; // RULE3 RULE4

  // Table steering decode
  wire opmode_t curMode = opmode_t'(mode_ff);
  wire tblop_t curOp = tblop_t'(tblOp);
  wire ptrHigh = 32'(tblPtr) >= INT_PM_WORDS;
  wire extSel = (curMode == MODE_MICROPROC) ||
    ((curMode == MODE_EXTENDED) && ptrHigh); // RULE10 RULE11
  wire tblTake = tblReq && (tblSt_ff == TS_IDLE);
  wire [15:0] latchIn = putByte(latch_ff, tblHigh, tblWdata); // RULE8

  always_comb begin
    nxt_bankSel = {hiNext, loNext};
    nxt_mode = (avWrAcc && selMode) ? avWritedata[1:0] : mode_ff;
    // A new dropped write wins over a clear in the same cycle
    nxt_discard = dropWr || (discard_ff &&
      !(avWrAcc && selStat && avWritedata[ST_DISCARD]));
  end

  always_comb begin
    nxt_tblSt = tblSt_ff;
    nxt_latch = latch_ff;
    nxt_tblRdata = tblRdata_ff;
    nxt_tblRvalid = 1'b0;
    nxt_pmAddr = pmAddr_ff;
    nxt_pmWdata = pmWdata_ff;
    nxt_pmRead = pmRead_ff;
    nxt_pmWrite = pmWrite_ff;
    nxt_pmExt = pmExt_ff;
    case (tblSt_ff)
      TS_IDLE: begin
        if (tblTake) begin
          case (curOp)
            TBL_LATCH_WR: begin
              nxt_latch = latchIn; // RULE8
            end
            TBL_PROG_WR: begin
              nxt_latch = latchIn;
              nxt_pmWdata = latchIn; // RULE9
              nxt_pmAddr = tblPtr; // RULE11
              nxt_pmWrite = 1'b1;
              nxt_pmExt = extSel; // RULE10
              nxt_tblSt = TS_PM_WAIT;
            end
            TBL_LATCH_RD: begin
              nxt_tblRdata = getByte(latch_ff, tblHigh); // RULE8
              nxt_tblRvalid = 1'b1;
            end
            default: begin
              // Byte comes from the latch, then the latch refills from memory
              nxt_tblRdata = getByte(latch_ff, tblHigh); // RULE9
              nxt_tblRvalid = 1'b1;
              nxt_pmAddr = tblPtr;
              nxt_pmRead = 1'b1;
              nxt_pmExt = extSel; // RULE10
              nxt_tblSt = TS_PM_WAIT;
            end
          endcase
        end
      end
      default: begin
        if (pmAck) begin
          if (pmRead_ff) begin
            nxt_latch = pmRdata; // RULE9
          end
          nxt_pmRead = 1'b0;
          nxt_pmWrite = 1'b0;
          nxt_tblSt = TS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bankSel_ff <= BANK_SEL_RST;
      mode_ff <= MODE_RST;
      discard_ff <= 1'b0;
      aluFlags_ff <= FLAGS_RST;
    end else begin
      bankSel_ff <= nxt_bankSel;
      mode_ff <= nxt_mode;
      discard_ff <= nxt_discard;
      if (aluFlagsWe) begin
        aluFlags_ff <= aluFlagsIn; // RULE6
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      avWaitreq_ff <= 1'b1;
      avRdata_ff <= 32'h0;
    end else begin
      // One wait cycle, then a single ready cycle
      avWaitreq_ff <= !(avReq && avWaitreq_ff);
      if (avReq && avWaitreq_ff) begin
        avRdata_ff <= avRead ? avRdNext : 32'h0;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdPend_ff <= 1'b0;
      rdOk_ff <= 1'b0;
      lastOk_ff <= 1'b1;
      dmRdata_ff <= 8'h00;
      dmRvalid_ff <= 1'b0;
    end else begin
      rdPend_ff <= dmRead;
      rdOk_ff <= bk.implemented;
      if (dmRead || dmWrite) begin
        lastOk_ff <= bk.implemented;
      end
      dmRvalid_ff <= rdPend_ff;
      dmRdata_ff <= (rdPend_ff && rdOk_ff) ? memRdata : 8'h00; // RULE5
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tblSt_ff <= TS_IDLE;
      latch_ff <= 16'h0000;
      tblReady_ff <= 1'b1;
      tblRdata_ff <= 8'h00;
      tblRvalid_ff <= 1'b0;
    end else begin
      tblSt_ff <= nxt_tblSt;
      latch_ff <= nxt_latch;
      tblReady_ff <= nxt_tblSt == TS_IDLE;
      tblRdata_ff <= nxt_tblRdata;
      tblRvalid_ff <= nxt_tblRvalid;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pmAddr_ff <= 16'h0000;
      pmWdata_ff <= 16'h0000;
      pmRead_ff <= 1'b0;
      pmWrite_ff <= 1'b0;
      pmExt_ff <= 1'b0;
    end else begin
      pmAddr_ff <= nxt_pmAddr;
      pmWdata_ff <= nxt_pmWdata;
      pmRead_ff <= nxt_pmRead;
      pmWrite_ff <= nxt_pmWrite;
      pmExt_ff <= nxt_pmExt;
    end
  end

  assign avReaddata = avRdata_ff;
  assign avWaitrequest = avWaitreq_ff;
  assign dmRdata = dmRdata_ff;
  assign dmRvalid = dmRvalid_ff;
  assign bankSelect = bankSel_ff;
  assign aluFlags = aluFlags_ff;
  assign tblReady = tblReady_ff;
  assign tblRdata = tblRdata_ff;
  assign tblRvalid = tblRvalid_ff;
  assign pmAddr = pmAddr_ff;
  assign pmWdata = pmWdata_ff;
  assign pmRead = pmRead_ff;
  assign pmWrite = pmWrite_ff;
  assign pmExternal = pmExt_ff;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_WINDOW: assert property (bk.inSfrWin == (dmAddr >= 8'h10 && dmAddr <= 8'h17)) // RULE1
    else $error("banked window decode wrong");
  AST_PBANK_STEER: assert property (bk.inSfrWin |->
    bk.physIdx[6:3] == bankSel_ff[3:0]) // RULE2
    else $error("peripheral bank not from lower nibble");
  AST_GPR_BANK: assert property (FULL_BANKING && dmAddr >= 8'h20 |->
    bk.physIdx[8] == bankSel_ff[4] && bk.physIdx[7:0] == dmAddr) // RULE3
    else $error("RAM bank not from upper nibble");
  AST_REDUCED: assert property (!FULL_BANKING |-> bankSel_ff[7:4] == 4'h0) // RULE4
    else $error("upper nibble present in reduced variant");
  AST_UNIMPL_ZERO: assert property (dmRead && !bk.implemented |->
    ##2 dmRvalid && dmRdata == 8'h00) // RULE5
    else $error("unimplemented bank read not zero");
  AST_DROP_WRITE: assert property (dmWrite && !bk.implemented |->
    !memWe ##1 discard_ff) // RULE6
    else $error("write to missing bank stored or not flagged");
  AST_FLAGS_ON_DROP: assert property (dropWr && aluFlagsWe |=>
    aluFlags == $past(aluFlagsIn)) // RULE6
    else $error("flags not updated on dropped write");
  AST_PASSTHRU: assert property ($stable(dmAddr) && dmAddr < 8'h10 |->
    $stable(bk.physIdx)) // RULE12
    else $error("low address moved by bank select");
  AST_PROG_WR_BYTE: assert property (tblTake && curOp == TBL_PROG_WR |=>
    pmWrite && getByte(pmWdata, $past(tblHigh)) == $past(tblWdata)) // RULE8
    else $error("table write byte lane wrong");
  AST_PROG_RD: assert property (tblTake && curOp == TBL_PROG_RD |=>
    pmRead && tblRvalid && pmAddr == $past(tblPtr) && !tblReady) // RULE9
    else $error("table read not issued");
  AST_EXT_MODE: assert property ((pmRead || pmWrite) && pmExternal |->
    $past(mode_ff) == MODE_MICROPROC || $past(mode_ff) == MODE_EXTENDED) // RULE10
    else $error("external access in internal-only mode");
  AST_PM_HOLD: assert property (tblSt_ff == TS_PM_WAIT && !pmAck |=>
    (pmRead || pmWrite) && $stable(pmAddr)) // RULE11
    else $error("program memory request dropped early");

  COV_UNIMPL_READ: cover property (dmRead && !bk.implemented ##2 dmRvalid);
  COV_PROG_WRITE: cover property (tblTake && curOp == TBL_PROG_WR ##[1:8] pmAck);
  COV_EXT_READ: cover property (pmRead && pmExternal ##[1:8] pmAck);
  COV_BUS_WRITE: cover property (avWrAcc && selBank);
endmodule

// ===== tb/pm_model.sv
// Program memory responder with a selectable answer delay
`timescale 1ns/1ps
module pm_model (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Request from the block
  input wire logic [15:0] pmAddr,
  input wire logic [15:0] pmWdata,
  input wire logic pmRead,
  input wire logic pmWrite,
  input wire logic [3:0] dly,
  // Answer
  output logic [15:0] pmRdata,
  output logic pmAck
);
  logic [15:0] mem [0:255];
  logic [3:0] cnt;
  wire req = pmRead | pmWrite;

  // Known contents so that a table read has something to find
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'hc000 | 16'(i);
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pmAck <= 1'b0;
      cnt <= 4'h0;
      pmRdata <= 16'h5a5a;
    end else if (pmAck) begin
      pmAck <= 1'b0;
      cnt <= 4'h0;
      pmRdata <= ~pmRdata;
    end else if (req && cnt >= dly) begin
      pmAck <= 1'b1;
      // Data only stands in the ack cycle; otherwise it keeps toggling
      pmRdata <= pmRead ? mem[pmAddr[7:0]] : ~pmRdata;
      if (pmWrite) begin
        mem[pmAddr[7:0]] <= pmWdata;
      end
    end else begin
      cnt <= req ? cnt + 4'h1 : 4'h0;
      pmRdata <= ~pmRdata;
    end
  end
endmodule

// ===== tb/test_data_bank_select_table_access.sv
// Testbench for the bank select and table access block
`timescale 1ns/1ps
module test_data_bank_select_table_access import bank_pkg::*;;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avAddress = 4'h0, avByteenable = 4'hf, bankNibble = 4'h0;
  logic [3:0] aluFlagsIn = 4'h0, dly = 4'h0, aluFlags;
  logic avRead = 1'b0, avWrite = 1'b0, dmRead = 1'b0, dmWrite = 1'b0;
  logic bankLoWe = 1'b0, bankHiWe = 1'b0, aluFlagsWe = 1'b0, tblReq = 1'b0, tblHigh = 1'b0;
  logic [31:0] avWritedata = 32'h0, avReaddata, q;
  logic [7:0] dmAddr = 8'h0, dmWdata = 8'h0, tblWdata = 8'h0, dmRdata, bankSelect, tblRdata;
  logic [7:0] bankSelR;
  logic [1:0] tblOp = 2'h0;
  logic [15:0] tblPtr = 16'h0, pmAddr, pmWdata, pmRdata, pa, pw;
  logic avWaitrequest, dmRvalid, tblReady, tblRvalid, pmRead, pmWrite, pmExternal, pmAck, ext;
  int err_count = 0;
  int cmp_count = 0;
  opmode_t md [6] = '{MODE_MICROCTRL, MODE_EXTENDED, MODE_EXTENDED, MODE_EXTENDED,
                      MODE_MICROPROC, MODE_PROTECTED};
  logic [15:0] pt [6] = '{16'hf000, 16'h07ff, 16'h0800, 16'hffff, 16'h0009, 16'hffff};
  logic ex [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  always #4 clock = ~clock;

  data_bank_select_table_access dut (.clock, .sys_rst, .avAddress, .avRead, .avWrite,
    .avWritedata, .avByteenable, .avReaddata, .avWaitrequest, .dmAddr, .dmRead, .dmWrite,
    .dmWdata, .dmRdata, .dmRvalid, .bankLoWe, .bankHiWe, .bankNibble, .bankSelect,
    .aluFlagsWe, .aluFlagsIn, .aluFlags, .tblReq, .tblOp, .tblHigh, .tblPtr, .tblWdata,
    .tblReady, .tblRdata, .tblRvalid, .pmAddr, .pmWdata, .pmRead, .pmWrite, .pmExternal,
    .pmRdata, .pmAck);

  // Reduced variant in lockstep; only its bank select byte is compared
  data_bank_select_table_access #(.FULL_BANKING(1'b0)) dutReduced (.clock, .sys_rst, .avAddress,
    .avRead, .avWrite, .avWritedata, .avByteenable, .avReaddata(), .avWaitrequest(), .dmAddr,
    .dmRead, .dmWrite, .dmWdata, .dmRdata(), .dmRvalid(), .bankLoWe, .bankHiWe, .bankNibble,
    .bankSelect(bankSelR), .aluFlagsWe, .aluFlagsIn, .aluFlags(), .tblReq, .tblOp, .tblHigh,
    .tblPtr, .tblWdata, .tblReady(), .tblRdata(), .tblRvalid(), .pmAddr(), .pmWdata(),
    .pmRead(), .pmWrite(), .pmExternal(), .pmRdata, .pmAck);

  pm_model pm (.clock, .sys_rst, .pmAddr, .pmWdata, .pmRead, .pmWrite, .dly, .pmRdata, .pmAck);

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tmo();
    err_count++;
    $display("[FAIL] %0t wait ran out", $time);
    stop_test();
  endtask

  // Avalon access; readdata is taken at the edge that sees waitrequest low
  task automatic av(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avAddress <= a;
    avWrite <= wr;
    avRead <= !wr;
    avWritedata <= {24'h0, d};
    do begin
      @(posedge clock);
      n++;
    end while (avWaitrequest !== 1'b0 && n < 40);
    if (avWaitrequest !== 1'b0) tmo();
    q = avReaddata;
    avWrite <= 1'b0;
    avRead <= 1'b0;
    // Let the committed write settle before callers look at outputs
    @(negedge clock);
  endtask

  task automatic bank(input logic hi, input logic [3:0] nib);
    @(posedge clock);
    bankLoWe <= !hi;
    bankHiWe <= hi;
    bankNibble <= nib;
    @(posedge clock);
    bankLoWe <= 1'b0;
    bankHiWe <= 1'b0;
  endtask

  // Core data access; a write also updates the flags from the data
  task automatic dm(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    dmAddr <= a;
    dmWrite <= wr;
    dmRead <= !wr;
    dmWdata <= d;
    aluFlagsWe <= wr;
    aluFlagsIn <= d[3:0];
    @(posedge clock);
    dmWrite <= 1'b0;
    dmRead <= 1'b0;
    aluFlagsWe <= 1'b0;
    // A write still waits half a cycle so flags and bank state have settled
    do begin
      @(negedge clock);
      n++;
    end while (!wr && dmRvalid !== 1'b1 && n < 4);
    if (!wr) begin
      if (dmRvalid !== 1'b1) tmo();
      q = {24'h0, dmRdata};
    end
  endtask

  task automatic tbl(input logic [1:0] op, input logic hi, input logic [15:0] p,
                     input logic [7:0] d);
    int n;
    n = 0;
    ext = 1'bx;
    pa = 16'hxxxx;
    @(posedge clock);
    tblReq <= 1'b1;
    tblOp <= op;
    tblHigh <= hi;
    tblPtr <= p;
    tblWdata <= d;
    @(posedge clock);
    tblReq <= 1'b0;
    do begin
      @(negedge clock);
      n++;
      if (tblRvalid === 1'b1) q = {24'h0, tblRdata};
      if (pmRead === 1'b1 || pmWrite === 1'b1) begin
        ext = pmExternal;
        pa = pmAddr;
        pw = pmWdata;
      end
    end while (tblReady !== 1'b1 && n < 40);
    if (tblReady !== 1'b1) tmo();
  endtask

  initial begin
    repeat (6) @(posedge clock);
    chk(32'(bankSelect), 32'(BANK_SEL_RST));
    chk(32'(tblReady), 32'h1);
    sys_rst <= 1'b0;
    av(1'b0, REG_MODE, 8'h0);
    chk(q, 32'(MODE_RST));
    av(1'b1, 4'hc, 8'hff);
    av(1'b0, 4'hc, 8'h0);
    chk(q, 32'h0);
    $display("reset test done");
    av(1'b1, REG_BANK_SEL, 8'h01);
    chk(32'(bankSelect), 32'h01);
    dm(1'b1, 8'h12, 8'ha1);
    bank(1'b0, 4'h0);
    dm(1'b1, 8'h12, 8'hb0);
    dm(1'b1, 8'h10, 8'h3c);
    dm(1'b1, 8'h08, 8'hc3);
    dm(1'b1, 8'h18, 8'h66);
    bank(1'b0, 4'h1);
    dm(1'b0, 8'h12, 8'h0);
    chk(q, 32'ha1);
    dm(1'b0, 8'h18, 8'h0);
    chk(q, 32'h66);
    bank(1'b0, 4'h0);
    dm(1'b0, 8'h12, 8'h0);
    chk(q, 32'hb0);
    $display("peripheral bank test done");
    dm(1'b1, 8'h30, 8'h11);
    bank(1'b1, 4'h1);
    dm(1'b1, 8'h30, 8'h22);
    chk(32'(bankSelect), 32'h10);
    chk(32'(bankSelR), 32'h00);
    dm(1'b0, 8'h08, 8'h0);
    chk(q, 32'hc3);
    bank(1'b1, 4'h0);
    dm(1'b0, 8'h30, 8'h0);
    chk(q, 32'h11);
    $display("ram bank test done");
    // Missing bank 13; reserved bank 15 is never read
    bank(1'b0, 4'hd);
    dm(1'b1, 8'h10, 8'h07);
    chk(32'(aluFlags), 32'h7);
    dm(1'b0, 8'h10, 8'h0);
    chk(q, 32'h0);
    av(1'b0, REG_STATUS, 8'h0);
    chk(q, 32'h1);
    av(1'b1, REG_STATUS, 8'h01);
    bank(1'b0, 4'h0);
    dm(1'b0, 8'h10, 8'h0);
    chk(q, 32'h3c);
    $display("unimplemented bank test done");
    tbl(2'h0, 1'b0, 16'h0, 8'h34);
    tbl(2'h1, 1'b1, 16'h0005, 8'h12);
    chk(32'(pw), 32'h1234);
    chk(32'(pa), 32'h0005);
    chk(32'(ext), 32'h0);
    tbl(2'h3, 1'b0, 16'h0009, 8'h0);
    tbl(2'h2, 1'b0, 16'h0, 8'h0);
    chk(q, 32'h09);
    tbl(2'h2, 1'b1, 16'h0, 8'h0);
    chk(q, 32'hc0);
    dly <= 4'h3;
    tbl(2'h3, 1'b0, 16'h0005, 8'h0);
    tbl(2'h2, 1'b1, 16'h0, 8'h0);
    chk(q, 32'h12);
    $display("table transfer test done");
    for (int i = 0; i < 6; i++) begin
      av(1'b1, REG_MODE, {6'h0, md[i]});
      tbl(2'h3, 1'b0, pt[i], 8'h0);
      chk(32'(ext), 32'(ex[i]));
      chk(32'(pa), 32'(pt[i]));
    end
    $display("mode test done");
    stop_test();
  end
endmodule
